// ### rtl/tp_strap_port.sv
// Purpose: test point port, strap capture at reset release, debug drive
// Assumes: pins are sampled synchronously; board resolves pad level from
//          tp_oe_n (low = driving) and tp_out
// Notes:   modes other than quiet and clock debug leave pins undriven;
//          debug clocks come from one free divider so their 8:4:2:1
//          ratios hold exactly, at the cost of absolute rate

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - pins stay inputs while reset held
// - after release pins become driven outputs in mode 010 only
// - capture at release, hold until next reset
// - sample only on reset rising edge
// - mode from lowest three pins only
// - mode 000 leaves all pins undriven
// - mode 010 drives clocks and fixed levels
// - reset active low, rise starts init
module tp_strap_port (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // test point pad, three-signal form
  input  wire logic [7:0] test_point_bus_in,
  output logic      [7:0] test_point_bus_out,
  output logic      [7:0] test_point_bus_oe_n,
  // captured mode for observation
  output logic      [2:0] test_mode
);

  logic       run;
  logic [2:0] strap_sync;
  logic       run_d;
  logic       capture;
  logic [3:0] div_cnt;

  // only the low three pins go to the synchroniser
  tp_strap_sync u_sync (
    .sys_clk         (sys_clk),
    .nrst            (nrst),
    .mode_strap_bits (test_point_bus_in[2:0]),
    .run             (run),
    .strap_sync      (strap_sync)
  );

  // single cycle pulse on synchronised release
  assign capture = run & ~run_d;

  // release tracker
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_d <= 1'b0;
    end else begin
      run_d <= run;
    end
  end

  // mode latch; only one capture per reset so late pin moves are ignored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      test_mode <= tp_strap_pkg::MODE_RESET;
    end else if (capture) begin
      test_mode <= strap_sync;
    end
  end

  // debug clock divider, held at zero until the mode is known
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= tp_strap_pkg::DIV_RESET;
    end else if (run_d) begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // pad enables; registered so pads never glitch on decode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      test_point_bus_oe_n <= tp_strap_pkg::OE_N_RESET;
    end else if (!run_d) begin
      test_point_bus_oe_n <= tp_strap_pkg::OE_N_RESET;
    end else begin
      case (test_mode)
        tp_strap_pkg::MODE_QUIET:     test_point_bus_oe_n <= tp_strap_pkg::OE_N_RESET;
        tp_strap_pkg::MODE_CLK_DEBUG: test_point_bus_oe_n <= 8'h00;
        default:                      test_point_bus_oe_n <= tp_strap_pkg::OE_N_RESET;
      endcase
    end
  end

  // pad data; clock pins follow divider taps, others fixed levels
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      test_point_bus_out <= tp_strap_pkg::OUT_RESET;
    end else if (run_d && (test_mode == tp_strap_pkg::MODE_CLK_DEBUG)) begin
      test_point_bus_out[0] <= div_cnt[tp_strap_pkg::PIN0_DIV_BIT];
      test_point_bus_out[1] <= div_cnt[tp_strap_pkg::PIN1_DIV_BIT];
      test_point_bus_out[2] <= div_cnt[tp_strap_pkg::PIN2_DIV_BIT];
      test_point_bus_out[3] <= tp_strap_pkg::PIN3_LEVEL;
      test_point_bus_out[4] <= tp_strap_pkg::PIN4_LEVEL;
      test_point_bus_out[5] <= tp_strap_pkg::PIN5_LEVEL;
      test_point_bus_out[6] <= tp_strap_pkg::PIN6_LEVEL;
      test_point_bus_out[7] <= div_cnt[tp_strap_pkg::PIN7_DIV_BIT];
    end else begin
      test_point_bus_out <= tp_strap_pkg::OUT_RESET;  // quiet pads carry no toggling
    end
  end

  // checks; with nrst first sampled high at edge R, run is seen at R+2,
  // the mode is loaded by R+2, run_d is seen high at R+3 and the pads
  // show the decoded drive from R+4 on; all checks sleep while nrst is
  // low so the async reset never trips them
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_inputs_at_release;
    $rose(nrst) |-> (test_point_bus_oe_n == 8'hFF) ##1 (test_point_bus_oe_n == 8'hFF);
  endproperty
  a_inputs_at_release: assert property (p_inputs_at_release) else $error("pins driven during reset");

  property p_drive_after_release;
    ($rose(run_d) && test_mode == 3'h2) |=> (test_point_bus_oe_n == 8'h00);
  endproperty
  a_drive_after_release: assert property (p_drive_after_release) else $error("pins not driven");

  property p_mode_held;
    run_d |=> $stable(test_mode);
  endproperty
  a_mode_held: assert property (p_mode_held) else $error("mode changed after capture");

  property p_capture_value;
    capture |=> (test_mode == $past(strap_sync));
  endproperty
  a_capture_value: assert property (p_capture_value) else $error("wrong strap captured");

  property p_upper_ignored;
    (run_d && test_mode == 3'h2 && $changed(test_point_bus_in[7:3])) |=> (test_point_bus_oe_n == 8'h00);
  endproperty
  a_upper_ignored: assert property (p_upper_ignored) else $error("upper pins disturbed port");

  property p_quiet;
    (run_d && test_mode == 3'h0) |=> (test_point_bus_oe_n == 8'hFF) [*2];
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet mode drove a pin");

  // the first driven cycle still shows the reset level on pin 0, so
  // the toggle check waits one more cycle after the drive starts
  property p_debug_levels;
    (run_d && $past(run_d) && test_mode == 3'h2) |=>
      (test_point_bus_out[6:3] == 4'hD) && (test_point_bus_out[0] != $past(test_point_bus_out[0]));
  endproperty
  a_debug_levels: assert property (p_debug_levels) else $error("debug mode output wrong");

  property p_release_latency;
    $rose(nrst) |-> ##[1:4] $rose(run_d);
  endproperty
  a_release_latency: assert property (p_release_latency) else $error("release not seen in time");

  property p_sync_gap;
    $rose(nrst) |-> !run_d ##1 !run_d;
  endproperty
  a_sync_gap: assert property (p_sync_gap) else $error("release not synchronised");

  property p_debug_first;
    ($rose(run_d) && test_mode == 3'h2) |=> (test_point_bus_out[6:3] == 4'hD);
  endproperty
  a_debug_first: assert property (p_debug_first) else $error("fixed levels late");

  // clock pins keep the 8:4:2:1 ratio: after a change pins 1, 2 and 7 hold their level 1, 3 and 7 more cycles
  property p_pin1_rate;
    (run_d && $past(run_d) && test_mode == 3'h2 && $changed(test_point_bus_out[1])) |=>
      $stable(test_point_bus_out[1]);
  endproperty
  a_pin1_rate: assert property (p_pin1_rate) else $error("pin 1 clock rate wrong");

  property p_pin2_rate;
    (run_d && $past(run_d) && test_mode == 3'h2 && $changed(test_point_bus_out[2])) |=>
      $stable(test_point_bus_out[2]) [*3];
  endproperty
  a_pin2_rate: assert property (p_pin2_rate) else $error("pin 2 clock rate wrong");

  property p_pin7_rate;
    (run_d && $past(run_d) && test_mode == 3'h2 && $changed(test_point_bus_out[7])) |=>
      $stable(test_point_bus_out[7]) [*7];
  endproperty
  a_pin7_rate: assert property (p_pin7_rate) else $error("pin 7 clock rate wrong");

  property p_quiet_out;
    (run_d && test_mode != 3'h2) |=> (test_point_bus_out == 8'h00);
  endproperty
  a_quiet_out: assert property (p_quiet_out) else $error("undriven mode toggles data");

  property p_idle_out;
    (test_point_bus_oe_n == 8'hFF) |-> (test_point_bus_out == 8'h00);
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("released pads carry data");

  property p_undriven_before_run;
    !run_d |=> (test_point_bus_oe_n == 8'hFF);
  endproperty
  a_undriven_before_run: assert property (p_undriven_before_run) else $error("pins driven too early");

  property p_release_exact;
    $rose(nrst) |-> ##3 $rose(run_d);
  endproperty
  a_release_exact: assert property (p_release_exact) else $error("release latency wrong");

  property p_mode_zero_at_release;
    $rose(nrst) |-> (test_mode == 3'h0);
  endproperty
  a_mode_zero_at_release: assert property (p_mode_zero_at_release) else $error("old mode kept over reset");

  c_quiet:   cover property (capture ##1 test_mode == 3'h0);
  c_debug:   cover property (capture ##1 test_mode == 3'h2 ##2 test_point_bus_oe_n == 8'h00);
  c_other:   cover property (capture ##1 test_mode == 3'h3);
  c_wrap:    cover property (run_d && div_cnt == 4'hF);
  c_late:    cover property (run_d && test_mode == 3'h0 && test_point_bus_in[2:0] != 3'h0);

endmodule

`default_nettype wire

// ### shared/tp_strap_pkg.sv
// Purpose: constants for the test point strap and debug port
// Assumes: 25 MHz system clock, eight test point pins
// Notes:   debug clock figures are kept for reference; the port can only
//          keep their ratios because it runs from the system clock

package tp_strap_pkg;

  localparam int unsigned PIN_COUNT  = 8;
  localparam int unsigned MODE_WIDTH = 3;
  localparam int unsigned DIV_WIDTH  = 4;

  // captured mode encodings
  localparam logic [2:0] MODE_QUIET     = 3'h0;
  localparam logic [2:0] MODE_CLK_DEBUG = 3'h2;

  // reset values
  localparam logic [7:0] OE_N_RESET = 8'hFF;
  localparam logic [7:0] OUT_RESET  = 8'h00;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [3:0] DIV_RESET  = 4'h0;

  // documented debug clock rates, in MHz
  localparam real PIN0_CLK_MHZ = 60.0;
  localparam real PIN1_CLK_MHZ = 30.0;
  localparam real PIN7_CLK_MHZ = 7.5;

  // divider bit driving each clock pin; rates keep the 8:4:2:1 ratios
  localparam int unsigned PIN0_DIV_BIT = 0;
  localparam int unsigned PIN1_DIV_BIT = 1;
  localparam int unsigned PIN2_DIV_BIT = 2;
  localparam int unsigned PIN7_DIV_BIT = 3;

  // fixed levels in clock debug mode, pins 3 to 6
  localparam logic PIN3_LEVEL = 1'b1;
  localparam logic PIN4_LEVEL = 1'b0;
  localparam logic PIN5_LEVEL = 1'b1;
  localparam logic PIN6_LEVEL = 1'b1;

endpackage

// ### rtl/tp_strap_sync.sv
// Purpose: bring reset release and strap levels into the sys_clk domain
// Assumes: sys_clk keeps running while nrst is held low
// Notes:   strap flops carry no reset so they can follow pins during reset

`timescale 1ns/1ps
`default_nettype none

module tp_strap_sync (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // raw pin levels
  input  wire logic [2:0] mode_strap_bits,
  // synchronised results
  output logic            run,
  output logic [2:0]      strap_sync
);

  logic       rst_meta;
  logic [2:0] strap_meta;

  // release synchroniser: assert at once, release after two edges
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      run      <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      run      <= rst_meta;
    end
  end

  // strap synchroniser, free running so it tracks pins under reset
  always_ff @(posedge sys_clk) begin
    strap_meta <= mode_strap_bits;
    strap_sync <= strap_meta;
  end

endmodule

`default_nettype wire

// ### test/tp_board_model.sv
// Purpose: board straps and probe seen at the test point pads
// Assumes: every pad has an internal pulldown
// Notes:   upper pulls stay low unless a test breaks the board advice
`timescale 1ns/1ps
`default_nettype none
module tp_board_model (
  // jumpers on the pads
  input  wire logic [2:0] strap_pull,
  input  wire logic [4:0] upper_pull,
  // device drive
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  // resolved pad level
  output logic      [7:0] pad_level
);
  // released pads fall to their pull, driven pads follow the device
  assign pad_level = (pad_out & ~pad_oe_n) | ({upper_pull, strap_pull} & pad_oe_n);
endmodule
`default_nettype wire

// ### test/tb.sv
// Purpose: self-checking bench for the test point strap port
// Assumes: 25 MHz sys_clk, pads resolved by the board model
// Notes:   debug clocks judged by toggle counts, not absolute rate
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       sys_clk   = 1'b0;
  logic       nrst      = 1'b0;
  logic [2:0] strap     = 3'h0;
  logic [4:0] upper     = 5'h00;
  logic [7:0] pad_in;
  logic [7:0] pad_out;
  logic [7:0] pad_oe_n;
  logic [2:0] test_mode;
  int         err_count = 0;
  int         checks    = 0;
  int         cycles    = 0;

  // 40 ns period
  always #20 sys_clk = ~sys_clk;

  tp_strap_port dut (.sys_clk(sys_clk), .nrst(nrst), .test_point_bus_in(pad_in),
    .test_point_bus_out(pad_out), .test_point_bus_oe_n(pad_oe_n), .test_mode(test_mode));
  tp_board_model board (.strap_pull(strap), .upper_pull(upper), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_level(pad_in));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, the run needs about 60 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      err_count++;
      wrap_up();
    end
  end

  // straps set with reset so they clear the synchroniser first
  task automatic strap_reset(input logic [2:0] s, input logic [4:0] u);
    @(posedge sys_clk);
    strap <= s;
    upper <= u;
    nrst  <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("oe_n in reset", pad_oe_n, 8'hFF);
    check("out in reset", pad_out, 8'h00);
    @(posedge sys_clk);
    @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_quiet();
    strap_reset(3'h0, 5'h00);
    check("quiet mode", 8'(test_mode), 8'h00);
    check("quiet oe_n", pad_oe_n, 8'hFF);
    @(posedge sys_clk);
    strap <= 3'h2;
    repeat (6) @(posedge sys_clk);
    #1;
    check("late strap", 8'(test_mode), 8'h00);
    check("late oe_n", pad_oe_n, 8'hFF);
    $display("test quiet done");
  endtask

  task automatic t_debug();
    logic [7:0] prev;
    int         n[8];
    strap_reset(3'h2, 5'h00);
    check("debug mode", 8'(test_mode), 8'h02);
    check("debug oe_n", pad_oe_n, 8'h00);
    check("fixed levels", 8'(pad_out[6:3]), 8'h0D);
    prev = pad_out;
    n = '{default: 0};
    // one full period of the slowest clock pin
    for (int c = 0; c < 16; c++) begin
      @(posedge sys_clk);
      #1;
      for (int b = 0; b < 8; b++) begin
        if (pad_out[b] !== prev[b]) begin
          n[b]++;
        end
      end
      prev = pad_out;
    end
    check("pin0 edges", 8'(n[0]), 8'h10);
    check("pin1 edges", 8'(n[1]), 8'h08);
    check("pin2 edges", 8'(n[2]), 8'h04);
    check("pin7 edges", 8'(n[7]), 8'h02);
    check("level edges", 8'(n[3] + n[4] + n[5] + n[6]), 8'h00);
    $display("test debug done");
  endtask

  task automatic t_upper();
    strap_reset(3'h2, 5'h1F);
    check("upper ignored", 8'(test_mode), 8'h02);
    strap_reset(3'h3, 5'h00);
    check("odd mode", 8'(test_mode), 8'h03);
    check("odd oe_n", pad_oe_n, 8'hFF);
    $display("test upper done");
  endtask

  initial begin
    t_quiet();
    t_debug();
    t_upper();
    wrap_up();
  end
endmodule
`default_nettype wire
